/* File: sdh_card_model.sv */
// Behavioural card-side partner: command responses and a read data stream.
`timescale 1ns/10ps
module sdh_card_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cmd_start,
  input  wire logic        dma_start,
  input  wire logic [5:0]  cmd_index,
  input  wire logic        rd_ready,
  input  wire logic [7:0]  n_words,
  input  wire logic [7:0]  resp_delay,
  input  wire logic        slow,
  input  wire logic        inject_err,
  output logic             card_cmd_done,
  output logic [31:0]      card_resp,
  output logic             card_block_gap,
  output logic             card_xfer_done,
  output logic             card_dma_err,
  output logic             card_rd_valid,
  output logic [31:0]      card_rd_data
);
  logic [7:0]  dly_q;
  logic [7:0]  sent_q;
  logic [1:0]  gap_q;
  logic        busy_q;
  logic        armed_q;
  logic        strm_q;
  wire  [31:0] word_w = 32'hD000_0000 + {24'h0, sent_q};

  // An idle data line shows the inverse so a stale word never looks valid.
  assign card_rd_data = card_rd_valid ? word_w : ~word_w;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {busy_q, armed_q, strm_q, card_rd_valid} <= 4'h0;
      {card_cmd_done, card_block_gap, card_xfer_done, card_dma_err} <= 4'h0;
      {dly_q, sent_q, gap_q} <= 18'h0;
      card_resp <= 32'h0;
    end
    else
    begin
      {card_cmd_done, card_block_gap, card_xfer_done, card_dma_err} <= 4'h0;
      if (strm_q && card_rd_valid && rd_ready)
      begin
        card_rd_valid <= 1'h0;
        sent_q <= sent_q + 8'h1;
        gap_q <= slow ? 2'h3 : 2'h0;
        card_block_gap <= (sent_q[1:0] == 2'h3);
        if (sent_q + 8'h1 == n_words)
        begin
          strm_q <= 1'h0;
          card_xfer_done <= !inject_err;
          card_dma_err <= inject_err;
        end
      end
      else if (strm_q && !card_rd_valid)
      begin
        if (gap_q != 2'h0)
          gap_q <= gap_q - 2'h1;
        else
          card_rd_valid <= 1'h1;
      end
      // Any new command, an abort included, ends a running stream.
      if (cmd_start)
      begin
        busy_q <= 1'h1;
        dly_q <= resp_delay;
        armed_q <= dma_start;
        strm_q <= 1'h0;
        card_rd_valid <= 1'h0;
        sent_q <= 8'h0;
        card_resp <= 32'hC000_0900 | {26'h0, cmd_index};
      end
      else if (busy_q && dly_q == 8'h0)
      begin
        busy_q <= 1'h0;
        card_cmd_done <= 1'h1;
        strm_q <= armed_q;
      end
      else if (busy_q)
        dly_q <= dly_q - 8'h1;
    end
  end
endmodule

/* File: sdh_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a flush.
`timescale 1ns/10ps
module sdh_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     flush,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign level     = wr_q - rd_q;
  assign in_ready  = (level != DEPTH[AW:0]);
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge aclk)
  begin
    if (!aresetn || flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule

/* File: sdh_pkg.sv */
// Package with register map, field positions, timing and state types.
// Behaviour
// - Command byte write issues command; DMA starts only with data-present and DMA-enable bits set.
// - Writing 1 clears transfer and DMA-error flags.
// - Card clock runs for abort; data stays halted.
// - Data-path reset bits self-clear when done.
package sdh_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_DESC    = 6'h00;
  localparam logic [5:0] OFS_BLOCK   = 6'h04;
  localparam logic [5:0] OFS_ARG     = 6'h08;
  localparam logic [5:0] OFS_CMD     = 6'h0C;
  localparam logic [5:0] OFS_PRESENT = 6'h10;
  localparam logic [5:0] OFS_CTRL    = 6'h14;
  localparam logic [5:0] OFS_RESET   = 6'h18;
  localparam logic [5:0] OFS_STATUS  = 6'h1C;
  localparam logic [5:0] OFS_DATA    = 6'h20;
  localparam logic [5:0] OFS_RESP    = 6'h24;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int XM_DMA_EN        = 0;
  localparam int XM_RESP_SUPPRESS = 8;
  localparam int CM_DATA_PRESENT  = 21;
  localparam int CM_INDEX_LSB     = 24;
  localparam int CTL_STOP_GAP     = 0;
  localparam int CTL_SPEED_LSB    = 8;
  localparam int RST_CMD          = 0;
  localparam int RST_DAT          = 1;
  localparam int RST_TRAN         = 2;
  localparam int ST_CMD_DONE      = 0;
  localparam int ST_XFER_DONE     = 1;
  localparam int ST_DMA_ERR       = 2;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_TIME_NS   = 80;
  localparam int RST_CYC =
    (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CARD_DIV      = 4;

  typedef enum logic [1:0] {
    SDH_DAT_IDLE = 2'b00,
    SDH_DAT_WAIT = 2'b01,
    SDH_DAT_RUN  = 2'b11
  } sdh_dat_state_t;

endpackage

/* File: sdh_xfer_ctrl.sv */
// Transfer, abort and speed control with AXI4-Lite register slave.
`timescale 1ns/10ps
module sdh_xfer_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [5:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             card_clk,
  output logic             cmd_start,
  output logic [5:0]       cmd_index,
  output logic [31:0]      cmd_arg,
  output logic             dma_start,
  output logic [31:0]      dma_addr,
  output logic [31:0]      block_cfg,
  output logic [2:0]       speed_mode,
  output logic             rd_ready,
  input  wire logic        card_cmd_done,
  input  wire logic [31:0] card_resp,
  input  wire logic        card_block_gap,
  input  wire logic        card_xfer_done,
  input  wire logic        card_dma_err,
  input  wire logic        card_rd_valid,
  input  wire logic [31:0] card_rd_data
);

  // ---------------------------------------------------------------
  // Register storage and control state
  // ---------------------------------------------------------------
  logic [31:0] desc_q, blk_q, arg_q, cmd_q, ctrl_q, resp_q;
  logic [2:0]  st_q, st_d, sw_rst_q;
  logic [3:0]  rst_cnt_q;
  logic        cmd_busy_q;
  logic [1:0]  div_q;
  sdh_pkg::sdh_dat_state_t dat_q, dat_d;
  logic [5:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_full_q, w_full_q;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic        fifo_in_ready, fifo_out_valid;
  logic [31:0] fifo_out_data;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  wire wr_fire   = aw_full_q & w_full_q & ~bvalid;
  wire hit_desc  = aw_q == sdh_pkg::OFS_DESC;
  wire hit_blk   = aw_q == sdh_pkg::OFS_BLOCK;
  wire hit_arg   = aw_q == sdh_pkg::OFS_ARG;
  wire hit_cmd   = aw_q == sdh_pkg::OFS_CMD;
  wire hit_ctrl  = aw_q == sdh_pkg::OFS_CTRL;
  wire hit_rst   = aw_q == sdh_pkg::OFS_RESET;
  wire hit_st    = aw_q == sdh_pkg::OFS_STATUS;
  wire wr_ok     = hit_desc | hit_blk | hit_arg | hit_cmd | hit_ctrl
                 | hit_rst | hit_st | (aw_q == sdh_pkg::OFS_PRESENT)
                 | (aw_q == sdh_pkg::OFS_DATA)
                 | (aw_q == sdh_pkg::OFS_RESP);
  wire [31:0] cmd_new = merge(cmd_q, w_q, ws_q);
  // A command write while the command line is busy is dropped whole.
  wire issue     = wr_fire & hit_cmd & ws_q[3] & ~cmd_busy_q;
  wire issue_dat = issue & cmd_new[sdh_pkg::CM_DATA_PRESENT];
  wire rst_wr    = wr_fire & hit_rst & ws_q[0];
  wire [2:0] rst_set = rst_wr ? w_q[2:0] : 3'h0;
  wire [2:0] st_clr  = (wr_fire & hit_st & ws_q[0]) ? w_q[2:0] : 3'h0;
  wire dat_flush = sw_rst_q[sdh_pkg::RST_DAT] | sw_rst_q[sdh_pkg::RST_TRAN];
  wire cmd_flush = sw_rst_q[sdh_pkg::RST_CMD];

  // ---------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------
  wire dat_run   = dat_q == sdh_pkg::SDH_DAT_RUN;
  wire stop_gap  = ctrl_q[sdh_pkg::CTL_STOP_GAP];
  wire cmd_evt   = cmd_busy_q & card_cmd_done
                 & ~cmd_q[sdh_pkg::XM_RESP_SUPPRESS];
  wire xfer_evt  = dat_run & ~dat_flush
                 & (card_xfer_done | (card_block_gap & stop_gap));
  wire dma_evt   = card_dma_err & (dat_q != sdh_pkg::SDH_DAT_IDLE);

  // Set wins over a same-cycle clear.
  assign st_d = (st_q & ~st_clr) | {dma_evt, xfer_evt, cmd_evt};

  // ---------------------------------------------------------------
  // Data path state
  // ---------------------------------------------------------------
  always_comb
  begin
    dat_d = dat_q;
    unique case (dat_q)
      sdh_pkg::SDH_DAT_IDLE:
        if (issue_dat)
          dat_d = sdh_pkg::SDH_DAT_WAIT;
      sdh_pkg::SDH_DAT_WAIT:
        if (card_cmd_done)
          dat_d = sdh_pkg::SDH_DAT_RUN;
      sdh_pkg::SDH_DAT_RUN:
        if (xfer_evt || dma_evt)
          dat_d = sdh_pkg::SDH_DAT_IDLE;
      default:
        dat_d = sdh_pkg::SDH_DAT_IDLE;
    endcase
    if (dat_flush)
      dat_d = sdh_pkg::SDH_DAT_IDLE;
  end

  // ---------------------------------------------------------------
  // Card clock and read flow
  // ---------------------------------------------------------------
  wire tick    = div_q == 2'(sdh_pkg::CARD_DIV - 1);
  // A full buffer halts a read by stopping the clock, but a pending
  // command keeps it running so an abort can still go out.
  wire clk_run = cmd_busy_q | (dat_run & fifo_in_ready);
  wire push    = card_rd_valid & rd_ready;

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  wire ar_fire  = arvalid & arready;
  wire rd_data  = araddr == sdh_pkg::OFS_DATA;
  wire pop      = ar_fire & rd_data & fifo_out_valid;
  wire [31:0] present = {16'h0000, 2'h0, 6'(fifo_level),
                         6'h00, dat_q != sdh_pkg::SDH_DAT_IDLE,
                         cmd_busy_q};
  wire rd_hit = (araddr == sdh_pkg::OFS_DESC)
              | (araddr == sdh_pkg::OFS_BLOCK)
              | (araddr == sdh_pkg::OFS_ARG)
              | (araddr == sdh_pkg::OFS_CMD)
              | (araddr == sdh_pkg::OFS_PRESENT)
              | (araddr == sdh_pkg::OFS_CTRL)
              | (araddr == sdh_pkg::OFS_RESET)
              | (araddr == sdh_pkg::OFS_STATUS)
              | rd_data | (araddr == sdh_pkg::OFS_RESP);
  wire [31:0] rd_mux =
      (araddr == sdh_pkg::OFS_DESC)    ? desc_q :
      (araddr == sdh_pkg::OFS_BLOCK)   ? blk_q :
      (araddr == sdh_pkg::OFS_ARG)     ? arg_q :
      (araddr == sdh_pkg::OFS_CMD)     ? cmd_q :
      (araddr == sdh_pkg::OFS_PRESENT) ? present :
      (araddr == sdh_pkg::OFS_CTRL)    ? ctrl_q :
      (araddr == sdh_pkg::OFS_RESET)   ? {29'h0, sw_rst_q} :
      (araddr == sdh_pkg::OFS_STATUS)  ? {29'h0, st_q} :
      (rd_data & fifo_out_valid)       ? fifo_out_data :
      (araddr == sdh_pkg::OFS_RESP)    ? resp_q : 32'h0000_0000;

  // ---------------------------------------------------------------
  // AXI4-Lite handshakes
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= sdh_pkg::RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= sdh_pkg::RESP_OKAY;
      rdata <= sdh_pkg::REG_RST;
      aw_q <= 6'h00;
      w_q <= sdh_pkg::REG_RST;
      ws_q <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_q <= awaddr;
        aw_full_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_q <= wdata;
        ws_q <= wstrb;
        w_full_q <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? sdh_pkg::RESP_OKAY : sdh_pkg::RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (ar_fire)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? sdh_pkg::RESP_OKAY : sdh_pkg::RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers, status and resets
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      desc_q <= sdh_pkg::REG_RST;
      blk_q <= sdh_pkg::REG_RST;
      arg_q <= sdh_pkg::REG_RST;
      cmd_q <= sdh_pkg::REG_RST;
      ctrl_q <= sdh_pkg::REG_RST;
      resp_q <= sdh_pkg::REG_RST;
      st_q <= 3'h0;
      sw_rst_q <= 3'h0;
      rst_cnt_q <= 4'h0;
    end
    else
    begin
      if (wr_fire && hit_desc)
        desc_q <= merge(desc_q, w_q, ws_q);
      if (wr_fire && hit_blk)
        blk_q <= merge(blk_q, w_q, ws_q);
      if (wr_fire && hit_arg)
        arg_q <= merge(arg_q, w_q, ws_q);
      if (wr_fire && hit_cmd && !cmd_busy_q)
        cmd_q <= cmd_new;
      if (wr_fire && hit_ctrl)
        ctrl_q <= merge(ctrl_q, w_q, ws_q);
      if (card_cmd_done && cmd_busy_q)
        resp_q <= card_resp;
      st_q <= st_d;
      // Reset bits hold for a fixed time, then clear themselves.
      if (rst_set != 3'h0)
      begin
        sw_rst_q <= sw_rst_q | rst_set;
        rst_cnt_q <= 4'(sdh_pkg::RST_CYC);
      end
      else if (rst_cnt_q == 4'h1)
      begin
        sw_rst_q <= 3'h0;
        rst_cnt_q <= 4'h0;
      end
      else if (rst_cnt_q != 4'h0)
        rst_cnt_q <= rst_cnt_q - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Command issue, DMA start, card clock
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_busy_q <= 1'b0;
      cmd_start <= 1'b0;
      dma_start <= 1'b0;
      cmd_index <= 6'h00;
      cmd_arg <= sdh_pkg::REG_RST;
      dma_addr <= sdh_pkg::REG_RST;
      block_cfg <= sdh_pkg::REG_RST;
      speed_mode <= 3'h0;
      dat_q <= sdh_pkg::SDH_DAT_IDLE;
      div_q <= 2'h0;
      card_clk <= 1'b0;
      rd_ready <= 1'b0;
    end
    else
    begin
      cmd_start <= issue;
      dma_start <= issue_dat & cmd_new[sdh_pkg::XM_DMA_EN];
      if (issue)
      begin
        cmd_busy_q <= 1'b1;
        cmd_index <= cmd_new[sdh_pkg::CM_INDEX_LSB +: 6];
        cmd_arg <= arg_q;
        dma_addr <= desc_q;
        block_cfg <= blk_q;
      end
      else if (card_cmd_done || cmd_flush)
        cmd_busy_q <= 1'b0;
      speed_mode <= ctrl_q[sdh_pkg::CTL_SPEED_LSB +: 3];
      dat_q <= dat_d;
      div_q <= tick ? 2'h0 : div_q + 2'h1;
      if (tick && clk_run)
        card_clk <= ~card_clk;
      rd_ready <= (dat_d == sdh_pkg::SDH_DAT_RUN) & fifo_in_ready
                & (fifo_level < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 1));
    end
  end

  sdh_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .flush     (dat_flush),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (card_rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  issue_start_a: assert property (
    issue |=> cmd_start && cmd_busy_q ##1 !cmd_start)
    else $error("command write did not start the command");
  dma_start_a: assert property (
    dma_start |-> $past(issue_dat) && dat_q == sdh_pkg::SDH_DAT_WAIT)
    else $error("DMA start without a data command");
  w1c_clear_a: assert property (
    (st_clr[sdh_pkg::ST_XFER_DONE] && !xfer_evt)
      |=> !st_q[sdh_pkg::ST_XFER_DONE])
    else $error("transfer flag not cleared by writing one");
  set_wins_a: assert property (
    dma_evt |=> st_q[sdh_pkg::ST_DMA_ERR])
    else $error("DMA error event lost");
  clk_abort_a: assert property (
    (cmd_busy_q && tick && !cmd_flush) |=> card_clk != $past(card_clk))
    else $error("card clock stopped during a command");
  dat_halt_a: assert property (
    !fifo_in_ready |=> !rd_ready)
    else $error("data accepted while buffer full");
  rst_clear_a: assert property (
    $rose(sw_rst_q[sdh_pkg::RST_DAT]) && rst_set == 3'h0
      |-> sw_rst_q[sdh_pkg::RST_DAT] [*4] ##1 !sw_rst_q[sdh_pkg::RST_DAT])
    else $error("data reset bit did not self-clear in time");
  rst_flush_a: assert property (
    dat_flush |=> dat_q == sdh_pkg::SDH_DAT_IDLE && fifo_level == '0)
    else $error("data reset left the data path busy");

  xfer_done_c: cover property (issue_dat ##[1:50] xfer_evt);
  gap_stop_c:  cover property (dat_run && stop_gap && card_block_gap);
  abort_c:     cover property (dat_run && issue);
  halt_c:      cover property (cmd_busy_q && !fifo_in_ready && tick);
endmodule

/* File: sdh_xfer_ctrl_bench.sv */
// Self-checking bench for the transfer, abort and speed control block.
`timescale 1ns/10ps
module sdh_xfer_ctrl_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, card_clk, cmd_start;
  logic dma_start, rd_ready, cmd_done, blk_gap, xfer_done, dma_err, rd_valid;
  logic slow, inject_err;
  logic [5:0]  awaddr, araddr, cmd_index;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [2:0]  speed_mode;
  logic [7:0]  n_words, resp_delay;
  logic [31:0] wdata, rdata, cmd_arg, dma_addr, block_cfg, resp, rd_data;
  int          fail_count, checks_done, n_cmd, n_dma;

  sdh_xfer_ctrl #(.FIFO_DEPTH(16)) i_sdh_xfer_ctrl (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .card_clk(card_clk),
    .cmd_start(cmd_start), .cmd_index(cmd_index), .cmd_arg(cmd_arg),
    .dma_start(dma_start), .dma_addr(dma_addr), .block_cfg(block_cfg),
    .speed_mode(speed_mode), .rd_ready(rd_ready),
    .card_cmd_done(cmd_done), .card_resp(resp),
    .card_block_gap(blk_gap), .card_xfer_done(xfer_done),
    .card_dma_err(dma_err), .card_rd_valid(rd_valid),
    .card_rd_data(rd_data));

  sdh_card_model i_sdh_card_model (.aclk(aclk), .aresetn(aresetn),
    .cmd_start(cmd_start), .dma_start(dma_start), .cmd_index(cmd_index),
    .rd_ready(rd_ready), .n_words(n_words), .resp_delay(resp_delay),
    .slow(slow), .inject_err(inject_err), .card_cmd_done(cmd_done),
    .card_resp(resp), .card_block_gap(blk_gap), .card_xfer_done(xfer_done),
    .card_dma_err(dma_err), .card_rd_valid(rd_valid),
    .card_rd_data(rd_data));

  always @(negedge aclk)
  begin
    n_cmd <= n_cmd + (aresetn && cmd_start === 1'h1);
    n_dma <= n_dma + (aresetn && dma_start === 1'h1);
  end

  task automatic check(input string what, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic timeout;
    fail_count++;
    $display("BAD wait expected answer seen none");
    test_done();
  endtask

  // ---------------------------------------------------------------
  // Register bus master
  // ---------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (n == 50) timeout();
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (n == 50) timeout();
    d = rdata;
    check("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'h0;
  endtask

  task automatic rdv(input string w, input logic [5:0] a,
                     input logic [31:0] m, exp);
    logic [31:0] d;
    rd(a, d);
    check(w, d & m, exp);
  endtask

  // Polls until the masked value equals val, or differs if ne.
  task automatic wait_reg(input logic [5:0] a, input logic [31:0] m, val,
                          input bit ne = 0);
    logic [31:0] d;
    int n;
    for (n = 0; n < 300; n++)
    begin
      rd(a, d);
      if (((d & m) == val) != ne) break;
    end
    if (n == 300) timeout();
  endtask

  task automatic clk_edges(input int cyc, output int e);
    logic last;
    e = 0;
    last = card_clk;
    repeat (cyc)
    begin
      @(posedge aclk);
      e += (card_clk !== last);
      last = card_clk;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    rdv("present", sdh_pkg::OFS_PRESENT, 32'hFFFF_FFFF, 32'h0);
    rdv("status", sdh_pkg::OFS_STATUS, 32'hFFFF_FFFF, 32'h0);
    rdv("ctrl", sdh_pkg::OFS_CTRL, 32'hFFFF_FFFF, 32'h0);
    rd(6'h28, d, sdh_pkg::RESP_SLVERR);
    check("unmapped", d, 32'h0);
    wr(6'h2C, 32'h1, sdh_pkg::RESP_SLVERR);
    $display("Test reset done");
  endtask

  task automatic t_cmd;
    wr(sdh_pkg::OFS_ARG, 32'h1234_5678);
    wr(sdh_pkg::OFS_CMD, 32'h0D00_0000);
    wait_reg(sdh_pkg::OFS_STATUS, 32'h1, 32'h1);
    check("cmds", n_cmd, 1);
    check("dmas", n_dma, 0);
    check("index", {26'h0, cmd_index}, 32'hD);
    check("arg", cmd_arg, 32'h1234_5678);
    rdv("resp", sdh_pkg::OFS_RESP, 32'hFFFF_FFFF, 32'hC000_090D);
    wr(sdh_pkg::OFS_STATUS, 32'h1);
    rdv("cmd clear", sdh_pkg::OFS_STATUS, 32'h7, 32'h0);
    wr(sdh_pkg::OFS_CMD, 32'h0D00_0100);
    wait_reg(sdh_pkg::OFS_PRESENT, 32'h1, 32'h0);
    rdv("suppress", sdh_pkg::OFS_STATUS, 32'h7, 32'h0);
    $display("Test command done");
  endtask

  task automatic t_dma;
    int i;
    {n_words, slow} <= {8'd20, 1'h0};
    wr(sdh_pkg::OFS_DESC, 32'h8000_1000);
    wr(sdh_pkg::OFS_BLOCK, 32'h0014_0004);
    wr(sdh_pkg::OFS_CMD, 32'h1221_0001);
    check("dma start", n_dma, 1);
    check("dma addr", dma_addr, 32'h8000_1000);
    check("block", block_cfg, 32'h0014_0004);
    wait_reg(sdh_pkg::OFS_PRESENT, 32'h3F00, 32'h0F00);
    check("fifo refuses", rd_ready, 1'h0);
    slow <= 1'h1;
    for (i = 0; i < 20; i++)
    begin
      wait_reg(sdh_pkg::OFS_PRESENT, 32'h3F00, 32'h0, 1);
      rdv("word", sdh_pkg::OFS_DATA, 32'hFFFF_FFFF, 32'hD000_0000 + i);
    end
    rdv("empty", sdh_pkg::OFS_DATA, 32'hFFFF_FFFF, 32'h0);
    wait_reg(sdh_pkg::OFS_STATUS, 32'h2, 32'h2);
    rdv("no err", sdh_pkg::OFS_STATUS, 32'h4, 32'h0);
    wr(sdh_pkg::OFS_STATUS, 32'h7);
    rdv("xfer clear", sdh_pkg::OFS_STATUS, 32'h7, 32'h0);
    $display("Test dma done");
  endtask

  task automatic t_err;
    {n_words, inject_err} <= {8'd2, 1'h1};
    wr(sdh_pkg::OFS_CMD, 32'h1221_0001);
    wait_reg(sdh_pkg::OFS_STATUS, 32'h4, 32'h4);
    rdv("err only", sdh_pkg::OFS_STATUS, 32'h2, 32'h0);
    wr(sdh_pkg::OFS_STATUS, 32'h7);
    rdv("err clear", sdh_pkg::OFS_STATUS, 32'h7, 32'h0);
    wr(sdh_pkg::OFS_CMD, 32'h0C00_0000);
    wr(sdh_pkg::OFS_RESET, 32'h2);
    wait_reg(sdh_pkg::OFS_RESET, 32'h2, 32'h0);
    $display("Test dma error done");
  endtask

  task automatic t_sync;
    int e;
    {n_words, slow, inject_err} <= {8'd40, 2'h0};
    wr(sdh_pkg::OFS_CMD, 32'h1221_0001);
    wr(sdh_pkg::OFS_CTRL, 32'h1);
    wait_reg(sdh_pkg::OFS_STATUS, 32'h2, 32'h2);
    wr(sdh_pkg::OFS_STATUS, 32'h7);
    clk_edges(24, e);
    check("clock halted", e, 0);
    resp_delay <= 8'd40;
    wr(sdh_pkg::OFS_CMD, 32'h0C00_0000);
    clk_edges(24, e);
    check("clock for abort", e != 0, 1);
    wait_reg(sdh_pkg::OFS_PRESENT, 32'h1, 32'h0);
    wr(sdh_pkg::OFS_CTRL, 32'h0);
    wr(sdh_pkg::OFS_RESET, 32'h2);
    wait_reg(sdh_pkg::OFS_RESET, 32'h2, 32'h0);
    rdv("flushed", sdh_pkg::OFS_PRESENT, 32'h3F03, 32'h0);
    $display("Test sync abort done");
  endtask

  task automatic t_async;
    int n;
    resp_delay <= 8'd200;
    wr(sdh_pkg::OFS_CMD, 32'h1200_0000);
    rdv("inhibit", sdh_pkg::OFS_PRESENT, 32'h1, 32'h1);
    n = n_cmd;
    wr(sdh_pkg::OFS_CMD, 32'h0C00_0000);
    check("dropped", n_cmd, n);
    check("index kept", {26'h0, cmd_index}, 32'h12);
    wr(sdh_pkg::OFS_RESET, 32'h1);
    wait_reg(sdh_pkg::OFS_RESET, 32'h1, 32'h0);
    rdv("cmd free", sdh_pkg::OFS_PRESENT, 32'h1, 32'h0);
    wr(sdh_pkg::OFS_CMD, 32'h3400_0000);
    check("abort issued", n_cmd, n + 1);
    check("io abort", {26'h0, cmd_index}, 32'h34);
    wr(sdh_pkg::OFS_RESET, 32'h4);
    wait_reg(sdh_pkg::OFS_RESET, 32'h4, 32'h0);
    $display("Test async abort done");
  endtask

  task automatic t_speed;
    int m;
    for (m = 0; m < 8; m++)
    begin
      wr(sdh_pkg::OFS_CTRL, m << sdh_pkg::CTL_SPEED_LSB);
      repeat (3) @(posedge aclk);
      check("speed", {29'h0, speed_mode}, m);
    end
    $display("Test speed done");
  endtask

  initial
  begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 48'h0;
    {slow, inject_err, n_words, resp_delay} = {2'h0, 8'd4, 8'd3};
    {fail_count, checks_done, n_cmd, n_dma} = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_cmd();
    t_dma();
    t_err();
    t_sync();
    t_async();
    t_speed();
    test_done();
  end
endmodule
